/* src/mft_cfg.svh */
// constants of the dual timer counter block
`ifndef MFT_CFG_SVH
`define MFT_CFG_SVH
// --------------------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------------------
`define MFT_ADR_CNT1     8'h00
`define MFT_ADR_RCA      8'h04
`define MFT_ADR_RCB      8'h08
`define MFT_ADR_CNT2     8'h0C
`define MFT_ADR_PRESCALE 8'h10
`define MFT_ADR_CLKSEL   8'h14
`define MFT_ADR_MODE     8'h18
`define MFT_ADR_IRQCTL   8'h1C
`define MFT_ADR_IRQCLR   8'h20
// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define MFT_PA_EDGE_BIT  2
`define MFT_PB_EDGE_BIT  3
`define MFT_PA_FUNC_BIT  4
`define MFT_PB_FUNC_BIT  5
`define MFT_PA_LEVEL_BIT 6
`define MFT_UNIT_ON_BIT  7
`define MFT_IRQ_EN_LSB   4
// --------------------------------------------------------------------------
// reset and fixed values
// --------------------------------------------------------------------------
`define MFT_RST_BYTE     8'h00
`define MFT_PRESET_VAL   16'hFFFF
`define MFT_CLR_READ     8'hFF
`endif

/* src/mft_pkg.sv */
// types of the dual timer counter block
package mft_pkg;
  typedef enum logic [1:0] {
    MFT_MODE_PWM   = 2'b00,
    MFT_MODE_CAP2  = 2'b01,
    MFT_MODE_DUAL  = 2'b10,
    MFT_MODE_CAP1  = 2'b11
  } mft_mode_t;

  typedef enum logic [2:0] {
    MFT_SRC_NONE   = 3'b000,
    MFT_SRC_PRESC  = 3'b001,
    MFT_SRC_EVENT  = 3'b010,
    MFT_SRC_ACCUM  = 3'b011,
    MFT_SRC_SLOW   = 3'b100
  } mft_src_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } mft_wb_req_t;
endpackage : mft_pkg

/* src/mft_timer.sv */
// dual timer counter with wishbone register slave
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "mft_cfg.svh"
module mft_timer (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire mft_pkg::mft_wb_req_t wb_req,
  output logic                      wb_ack_o,
  output logic [31:0]               wb_dat_o,
  input  wire logic                 pin_a_io_in,
  output logic                      pin_a_io_out,
  output logic                      pin_a_io_oe,
  input  wire logic                 pin_b_io_in,
  input  wire logic                 slow_clk_in,
  output logic                      timer_irq_one,
  output logic                      timer_irq_two
);
  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [4:0]        prescale_field;
  logic [2:0]        counter_one_source;
  logic [2:0]        counter_two_source;
  logic [15:0]       counter_one_value;
  logic [15:0]       counter_two_value;
  logic [15:0]       reload_capture_a;
  logic [15:0]       reload_capture_b;
  mft_pkg::mft_mode_t mode_field;
  logic              pin_a_edge_sel;
  logic              pin_b_edge_sel;
  logic              pin_a_function_on;
  logic              pin_b_function_on;
  logic              pin_a_level;
  logic              unit_on;
  logic [3:0]        irq_on;
  logic [3:0]        flag;
  logic [4:0]        presc_cnt;
  logic              pwm_phase;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  logic       req;
  logic       wr;
  logic       wr_cnt1;
  logic       wr_cnt2;
  logic       wr_rca;
  logic       wr_rcb;
  logic       wr_presc;
  logic       wr_clksel;
  logic       wr_mode;
  logic       wr_irqctl;
  logic       wr_irqclr;
  logic [7:0] wbyte;
  logic [1:0] lane;

  assign req   = wb_req.cyc & wb_req.stb & ~wb_ack_o;
  assign wr    = req & wb_req.we;
  assign wbyte = wb_req.dat[7:0];
  assign lane  = wb_req.sel[1:0];

  always_comb begin
    wr_cnt1   = 1'b0;
    wr_cnt2   = 1'b0;
    wr_rca    = 1'b0;
    wr_rcb    = 1'b0;
    wr_presc  = 1'b0;
    wr_clksel = 1'b0;
    wr_mode   = 1'b0;
    wr_irqctl = 1'b0;
    wr_irqclr = 1'b0;
    if (wb_req.adr == `MFT_ADR_CNT1) begin
      wr_cnt1 = wr & unit_on;
    end else if (wb_req.adr == `MFT_ADR_CNT2) begin
      wr_cnt2 = wr & unit_on;
    end else if (wb_req.adr == `MFT_ADR_RCA) begin
      wr_rca = wr & unit_on;
    end else if (wb_req.adr == `MFT_ADR_RCB) begin
      wr_rcb = wr & unit_on;
    end else if (wb_req.adr == `MFT_ADR_PRESCALE) begin
      wr_presc = wr & wb_req.sel[0];
    end else if (wb_req.adr == `MFT_ADR_CLKSEL) begin
      wr_clksel = wr & wb_req.sel[0];
    end else if (wb_req.adr == `MFT_ADR_MODE) begin
      wr_mode = wr & wb_req.sel[0];
    end else if (wb_req.adr == `MFT_ADR_IRQCTL) begin
      wr_irqctl = wr & wb_req.sel[0];
    end else if (wb_req.adr == `MFT_ADR_IRQCLR) begin
      wr_irqclr = wr & wb_req.sel[0];
    end
  end

  // --------------------------------------------------------------------------
  // pin and slow clock synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] sync_in;
  logic [2:0] sync_s1;
  logic [2:0] sync_s2;
  logic [2:0] sync_s3;

  assign sync_in = {slow_clk_in, pin_b_io_in, pin_a_io_in};

  genvar gs;
  generate
    for (gs = 0; gs < 3; gs++) begin : g_sync
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync_s1[gs] <= 1'b0;
          sync_s2[gs] <= 1'b0;
          sync_s3[gs] <= 1'b0;
        end else begin
          sync_s1[gs] <= sync_in[gs];
          sync_s2[gs] <= sync_s1[gs];
          sync_s3[gs] <= sync_s2[gs];
        end
      end
    end
  endgenerate

  logic pa_edge;
  logic pb_edge;
  logic slow_tick;
  logic pb_level_ok;

  assign pa_edge     = pin_a_edge_sel ? (sync_s2[0] & ~sync_s3[0]) : (~sync_s2[0] & sync_s3[0]);
  assign pb_edge     = pin_b_edge_sel ? (sync_s2[1] & ~sync_s3[1]) : (~sync_s2[1] & sync_s3[1]);
  assign pb_level_ok = (sync_s2[1] == pin_b_edge_sel);
  assign slow_tick   = sync_s2[2] & ~sync_s3[2];

  // --------------------------------------------------------------------------
  // prescaler
  // --------------------------------------------------------------------------
  logic presc_tick;

  // a stale count above a newly written field ticks at once instead of wrapping
  assign presc_tick = unit_on & (presc_cnt >= prescale_field);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      presc_cnt <= 5'h0;
    end else if (!unit_on || presc_tick) begin
      presc_cnt <= 5'h0;
    end else begin
      presc_cnt <= presc_cnt + 5'h1;
    end
  end

  // --------------------------------------------------------------------------
  // counter clock selection
  // --------------------------------------------------------------------------
  function automatic logic src_tick(input logic [2:0] src, input logic pt, input logic ev,
                                    input logic lvl, input logic st);
    logic t;
    t = 1'b0;
    case (src)
      mft_pkg::MFT_SRC_PRESC: t = pt;
      mft_pkg::MFT_SRC_EVENT: t = ev;
      mft_pkg::MFT_SRC_ACCUM: t = pt & lvl;
      mft_pkg::MFT_SRC_SLOW:  t = st;
      default:                t = 1'b0;
    endcase
    return t;
  endfunction : src_tick

  logic cap_mode;
  logic c1_tick;
  logic c2_tick;

  // event and accumulate inputs only exist while pin b is not a capture input
  assign cap_mode = (mode_field == mft_pkg::MFT_MODE_CAP2) || (mode_field == mft_pkg::MFT_MODE_CAP1);
  assign c1_tick  = unit_on & src_tick(counter_one_source, presc_tick, pb_edge & ~cap_mode,
                                       pb_level_ok & ~cap_mode, slow_tick);
  assign c2_tick  = unit_on & src_tick(counter_two_source, presc_tick, pb_edge & ~cap_mode,
                                       pb_level_ok & ~cap_mode, slow_tick);

  // --------------------------------------------------------------------------
  // mode events
  // --------------------------------------------------------------------------
  logic c1_uf;
  logic c2_uf;
  logic cap_a;
  logic cap_b1;
  logic cap_b2;
  logic c1_preset;
  logic c2_preset;
  logic reload_mode;
  logic pwm_pin;
  logic [15:0] c1_reload;
  logic [3:0]  hw_ev;

  assign c1_uf       = c1_tick & (counter_one_value == 16'h0000);
  assign c2_uf       = c2_tick & (counter_two_value == 16'h0000);
  assign cap_a       = unit_on & (mode_field == mft_pkg::MFT_MODE_CAP2) & pa_edge;
  assign cap_b1      = unit_on & (mode_field == mft_pkg::MFT_MODE_CAP2) & pb_edge;
  assign cap_b2      = unit_on & (mode_field == mft_pkg::MFT_MODE_CAP1) & pb_edge;
  assign c1_preset   = (cap_a & pin_a_function_on) | (cap_b1 & pin_b_function_on);
  assign c2_preset   = cap_b2 & pin_b_function_on;
  assign reload_mode = (mode_field != mft_pkg::MFT_MODE_CAP2);
  assign pwm_pin     = pin_a_function_on & reload_mode;
  assign c1_reload   = ((mode_field == mft_pkg::MFT_MODE_PWM) && pwm_phase) ? reload_capture_b : reload_capture_a;

  always_comb begin
    hw_ev = 4'h0;
    case (mode_field)
      mft_pkg::MFT_MODE_PWM: begin
        hw_ev[0] = c1_uf & ~pwm_phase;
        hw_ev[1] = c1_uf & pwm_phase;
        hw_ev[3] = c2_uf;
      end
      mft_pkg::MFT_MODE_CAP2: begin
        hw_ev[0] = cap_a;
        hw_ev[1] = cap_b1;
        hw_ev[2] = c1_uf;
        hw_ev[3] = c2_uf;
      end
      mft_pkg::MFT_MODE_DUAL: begin
        hw_ev[0] = c1_uf;
        hw_ev[3] = c2_uf;
      end
      default: begin
        hw_ev[0] = c1_uf;
        hw_ev[1] = cap_b2;
        hw_ev[3] = c2_uf;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwm_phase <= 1'b0;
    end else if (mode_field != mft_pkg::MFT_MODE_PWM) begin
      pwm_phase <= 1'b0;
    end else if (c1_uf) begin
      pwm_phase <= ~pwm_phase;
    end
  end

  // --------------------------------------------------------------------------
  // count and reload/capture words, kept through reset
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (wr_cnt1) begin
      if (lane[0]) counter_one_value[7:0] <= wb_req.dat[7:0];
      if (lane[1]) counter_one_value[15:8] <= wb_req.dat[15:8];
    end else if (c1_preset) begin
      counter_one_value <= `MFT_PRESET_VAL;
    end else if (c1_tick) begin
      counter_one_value <= c1_uf ? (reload_mode ? c1_reload : `MFT_PRESET_VAL) : counter_one_value - 16'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_cnt2) begin
      if (lane[0]) counter_two_value[7:0] <= wb_req.dat[7:0];
      if (lane[1]) counter_two_value[15:8] <= wb_req.dat[15:8];
    end else if (c2_preset) begin
      counter_two_value <= `MFT_PRESET_VAL;
    end else if (c2_tick) begin
      counter_two_value <= c2_uf ? ((mode_field == mft_pkg::MFT_MODE_DUAL) ? reload_capture_b : `MFT_PRESET_VAL)
                                 : counter_two_value - 16'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_rca) begin
      if (lane[0]) reload_capture_a[7:0] <= wb_req.dat[7:0];
      if (lane[1]) reload_capture_a[15:8] <= wb_req.dat[15:8];
    end else if (cap_a) begin
      reload_capture_a <= counter_one_value;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_rcb) begin
      if (lane[0]) reload_capture_b[7:0] <= wb_req.dat[7:0];
      if (lane[1]) reload_capture_b[15:8] <= wb_req.dat[15:8];
    end else if (cap_b1) begin
      reload_capture_b <= counter_one_value;
    end else if (cap_b2) begin
      reload_capture_b <= counter_two_value;
    end
  end

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prescale_field     <= 5'h0;
      counter_one_source <= 3'h0;
      counter_two_source <= 3'h0;
    end else begin
      if (wr_presc) prescale_field <= wbyte[4:0];
      if (wr_clksel) begin
        counter_one_source <= wbyte[2:0];
        counter_two_source <= wbyte[5:3];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_field        <= mft_pkg::MFT_MODE_PWM;
      pin_a_edge_sel    <= 1'b0;
      pin_b_edge_sel    <= 1'b0;
      pin_a_function_on <= 1'b0;
      pin_b_function_on <= 1'b0;
      unit_on           <= 1'b0;
    end else if (wr_mode) begin
      mode_field        <= mft_pkg::mft_mode_t'(wbyte[1:0]);
      pin_a_edge_sel    <= wbyte[`MFT_PA_EDGE_BIT];
      pin_b_edge_sel    <= wbyte[`MFT_PB_EDGE_BIT];
      pin_a_function_on <= wbyte[`MFT_PA_FUNC_BIT];
      pin_b_function_on <= wbyte[`MFT_PB_FUNC_BIT];
      unit_on           <= wbyte[`MFT_UNIT_ON_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_a_level <= 1'b0;
    end else if (wr_mode) begin
      pin_a_level <= wbyte[`MFT_PA_LEVEL_BIT];
    end else if (c1_uf && pwm_pin) begin
      pin_a_level <= ~pin_a_level;
    end
  end

  // --------------------------------------------------------------------------
  // interrupt enables and pending flags
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_on <= 4'h0;
    end else if (wr_irqctl) begin
      irq_on <= wbyte[7:4];
    end
  end

  genvar gf;
  generate
    for (gf = 0; gf < 4; gf++) begin : g_flag
      logic sw_set;
      logic sw_clr;
      assign sw_set = wr_irqctl & unit_on & wbyte[gf];
      assign sw_clr = wr_irqclr & wbyte[gf];
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          flag[gf] <= 1'b0;
        end else if (!unit_on) begin
          flag[gf] <= 1'b0;
        end else begin
          flag[gf] <= (flag[gf] & ~sw_clr) | hw_ev[gf] | sw_set;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_irq_one <= 1'b0;
      timer_irq_two <= 1'b0;
    end else begin
      timer_irq_one <= |(flag[2:0] & irq_on[2:0]);
      timer_irq_two <= flag[3] & irq_on[3];
    end
  end

  assign pin_a_io_out = pin_a_level;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_a_io_oe <= 1'b0;
    end else begin
      pin_a_io_oe <= unit_on & pwm_pin;
    end
  end

  // --------------------------------------------------------------------------
  // read data and acknowledge
  // --------------------------------------------------------------------------
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    if (wb_req.adr == `MFT_ADR_CNT1) begin
      rdata[15:0] = counter_one_value;
    end else if (wb_req.adr == `MFT_ADR_CNT2) begin
      rdata[15:0] = counter_two_value;
    end else if (wb_req.adr == `MFT_ADR_RCA) begin
      rdata[15:0] = reload_capture_a;
    end else if (wb_req.adr == `MFT_ADR_RCB) begin
      rdata[15:0] = reload_capture_b;
    end else if (wb_req.adr == `MFT_ADR_PRESCALE) begin
      rdata[4:0] = prescale_field;
    end else if (wb_req.adr == `MFT_ADR_CLKSEL) begin
      rdata[5:0] = {counter_two_source, counter_one_source};
    end else if (wb_req.adr == `MFT_ADR_MODE) begin
      rdata[7:0] = {unit_on, pin_a_level, pin_b_function_on, pin_a_function_on,
                    pin_b_edge_sel, pin_a_edge_sel, mode_field};
    end else if (wb_req.adr == `MFT_ADR_IRQCTL) begin
      rdata[7:0] = {irq_on, flag};
    end else if (wb_req.adr == `MFT_ADR_IRQCLR) begin
      rdata[7:0] = `MFT_CLR_READ;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_req.we) wb_dat_o <= rdata;
    end
  end
endmodule : mft_timer

/* verification/mft_pin_model.sv */
// pin-side partner: drives the timer pins and the slow clock
`timescale 1ns/10ps
module mft_pin_model (
  input  wire logic core_clk,
  input  wire logic a_lvl,
  input  wire logic b_lvl,
  input  wire logic slow_run,
  input  wire logic pin_a_io_out,
  input  wire logic pin_a_io_oe,
  output logic      pin_a_io_in,
  output logic      pin_b_io_in,
  output logic      slow_clk_in
);
  int div;
  // wire level: the timer wins while it drives pin a
  assign pin_a_io_in = pin_a_io_oe ? pin_a_io_out : a_lvl;
  // levels held many clocks, well above one clock
  assign pin_b_io_in = b_lvl;
  // slow clock stands low unless asked to run
  always @(posedge core_clk) begin
    if (!slow_run) begin
      div <= 0;
      slow_clk_in <= 1'b0;
    end else if (div == 19) begin
      div <= 0;
      slow_clk_in <= ~slow_clk_in;
    end else begin
      div <= div + 1;
    end
  end
endmodule : mft_pin_model

/* verification/mft_timer_checker.sv */
// port assertions of the dual timer counter
`timescale 1ns/10ps
`include "mft_cfg.svh"
module mft_timer_checker (
  input wire logic                 core_clk,
  input wire logic                 rst,
  input wire mft_pkg::mft_wb_req_t wb_req,
  input wire logic                 wb_ack_o,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 pin_a_io_oe,
  input wire logic                 timer_irq_one,
  input wire logic                 timer_irq_two
);
  logic take;
  logic wr;
  assign take = wb_req.cyc && wb_req.stb && !wb_ack_o;
  assign wr = take && wb_req.we && wb_req.sel[0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ack_latency_a: assert property (take |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  clr_read_a: assert property (take && !wb_req.we && wb_req.adr == `MFT_ADR_IRQCLR
    |=> wb_dat_o == 32'h0000_00FF)
    else $error("clear register read not FF");
  read_upper_a: assert property (take && !wb_req.we |=> wb_dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  irq_two_mask_a: assert property (wr && wb_req.adr == `MFT_ADR_IRQCTL && !wb_req.dat[7] |-> ##2 !timer_irq_two)
    else $error("second interrupt while source d masked");
  irq_one_mask_a: assert property (wr && wb_req.adr == `MFT_ADR_IRQCTL && wb_req.dat[6:4] == 3'b000
    |-> ##2 !timer_irq_one)
    else $error("first interrupt while a b c masked");
  unit_off_a: assert property (wr && wb_req.adr == `MFT_ADR_MODE && !wb_req.dat[7]
    |-> ##2 !pin_a_io_oe ##1 !(timer_irq_one || timer_irq_two))
    else $error("unit off left pin driven or interrupt up");
  oe_cause_a: assert property ($changed(pin_a_io_oe) |-> $past(wr && wb_req.adr == `MFT_ADR_MODE, 2))
    else $error("pin a enable changed without mode write");
endmodule : mft_timer_checker

/* verification/testbench.sv */
// self-checking bench of the dual timer counter
`timescale 1ns/10ps
`include "mft_cfg.svh"
module testbench;
  logic                 core_clk;
  logic                 rst;
  mft_pkg::mft_wb_req_t wb_req;
  logic                 wb_ack_o;
  logic [31:0]          wb_dat_o;
  logic                 pin_a_io_in;
  logic                 pin_a_io_out;
  logic                 pin_a_io_oe;
  logic                 pin_b_io_in;
  logic                 slow_clk_in;
  logic                 timer_irq_one;
  logic                 timer_irq_two;
  logic                 a_lvl;
  logic                 b_lvl;
  logic                 slow_run;
  logic                 prev;
  logic [7:0]           rnd;
  logic [15:0]          v;
  logic [32:0]          note;
  logic [32:0]          notes[$];
  logic [31:0]          got;
  logic [7:0]           regs[4] = '{`MFT_ADR_CNT1, `MFT_ADR_RCA, `MFT_ADR_RCB, `MFT_ADR_CNT2};
  int                   pv[3] = '{0, 3, 31};
  int                   fails;
  int                   comparisons;
  int                   cycles;
  int                   toggles;
  mft_timer dut (.core_clk, .rst, .wb_req, .wb_ack_o, .wb_dat_o, .pin_a_io_in, .pin_a_io_out, .pin_a_io_oe,
    .pin_b_io_in, .slow_clk_in, .timer_irq_one, .timer_irq_two);
  mft_pin_model pins (.core_clk, .a_lvl, .b_lvl, .slow_run, .pin_a_io_out, .pin_a_io_oe, .pin_a_io_in,
    .pin_b_io_in, .slow_clk_in);
  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ck,
    input logic [31:0] e);
    notes.push_back({ck, e});
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    got = wb_dat_o;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0, 32'h0000_0000);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 1'b1, e);
  endtask : rd
  task automatic win(input logic [15:0] base, input int lo, input int hi);
    chk(32'((base - got[15:0]) >= lo && (base - got[15:0]) <= hi), 32'h0000_0001);
  endtask : win
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_clk
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      if (note[32]) chk(wb_dat_o, note[31:0]);
    end
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    rst = 1'b1; wb_req = '0; a_lvl = 1'b0; b_lvl = 1'b0; slow_run = 1'b0; prev = 1'b0;
    rnd = 8'h42; fails = 0; comparisons = 0; cycles = 0; toggles = 0;
    wait_clk(12);
    rst <= 1'b0;
    rd(`MFT_ADR_PRESCALE, 0);
    rd(`MFT_ADR_CLKSEL, 0);
    rd(`MFT_ADR_MODE, 0);
    rd(`MFT_ADR_IRQCTL, 0);
    rd(`MFT_ADR_IRQCLR, 8'hFF);
    rd(8'h24, 0);
    wr(`MFT_ADR_MODE, 8'h82);
    foreach (regs[i]) begin
      rnd = lfsr(lfsr(rnd)); v = {rnd, lfsr(rnd)};
      wr(regs[i], v); rd(regs[i], v);
    end
    wr(`MFT_ADR_MODE, 8'h02);
    wr(`MFT_ADR_CNT2, ~v); rd(`MFT_ADR_CNT2, v);
    wr(`MFT_ADR_IRQCTL, 8'h0F); rd(`MFT_ADR_IRQCTL, 0);
    wr(`MFT_ADR_MODE, 8'h82);
    wr(`MFT_ADR_IRQCTL, 8'h0F); rd(`MFT_ADR_IRQCTL, 8'h0F);
    wr(`MFT_ADR_IRQCTL, 8'hF0); rd(`MFT_ADR_IRQCTL, 8'hFF);
    chk(32'(timer_irq_one), 1); chk(32'(timer_irq_two), 1);
    wr(`MFT_ADR_IRQCLR, 8'h01); rd(`MFT_ADR_IRQCTL, 8'hFE);
    wr(`MFT_ADR_IRQCLR, 8'hF0); rd(`MFT_ADR_IRQCTL, 8'hFE);
    wr(`MFT_ADR_IRQCLR, 8'h06); rd(`MFT_ADR_IRQCTL, 8'hF8);
    chk(32'(timer_irq_one), 0); chk(32'(timer_irq_two), 1);
    wr(`MFT_ADR_IRQCTL, 8'h70); chk(32'(timer_irq_two), 0);
    wr(`MFT_ADR_MODE, 8'h02); rd(`MFT_ADR_IRQCTL, 8'h70);
    wr(`MFT_ADR_MODE, 8'h82);
    foreach (pv[i]) begin
      wr(`MFT_ADR_PRESCALE, pv[i]); wr(`MFT_ADR_CNT1, 16'h1000); wr(`MFT_ADR_CLKSEL, 8'h01);
      wait_clk((pv[i] + 1) * 50); wr(`MFT_ADR_CLKSEL, 8'h00);
      bus(1'b0, `MFT_ADR_CNT1, 0, 1'b0, 0); win(16'h1000, 49, 54);
    end
    wr(`MFT_ADR_CNT1, 16'h1000);
    for (int c = 5; c < 8; c++) begin
      wr(`MFT_ADR_CLKSEL, c); wait_clk(20);
    end
    rd(`MFT_ADR_CNT1, 16'h1000);
    wr(`MFT_ADR_MODE, 8'h8A); wr(`MFT_ADR_CNT1, 16'h0100); wr(`MFT_ADR_CLKSEL, 8'h02);
    repeat (10) begin
      b_lvl <= ~b_lvl; wait_clk(8);
    end
    wr(`MFT_ADR_CLKSEL, 8'h00); rd(`MFT_ADR_CNT1, 16'h00FB);
    wr(`MFT_ADR_PRESCALE, 0); wr(`MFT_ADR_CNT1, 16'h0100); wr(`MFT_ADR_CLKSEL, 8'h03); wait_clk(20);
    b_lvl <= 1'b1; wait_clk(40); wr(`MFT_ADR_CLKSEL, 8'h00); b_lvl <= 1'b0;
    bus(1'b0, `MFT_ADR_CNT1, 0, 1'b0, 0); win(16'h0100, 38, 40);
    slow_run <= 1'b1; wr(`MFT_ADR_CNT2, 16'h1000); wr(`MFT_ADR_CLKSEL, 8'h20);
    wait_clk(800); wr(`MFT_ADR_CLKSEL, 8'h00); slow_run <= 1'b0;
    bus(1'b0, `MFT_ADR_CNT2, 0, 1'b0, 0); win(16'h1000, 19, 21);
    rnd = lfsr(lfsr(rnd)); v = {rnd, lfsr(rnd)};
    wr(`MFT_ADR_CNT1, v); wr(`MFT_ADR_MODE, 8'h95); chk(32'(pin_a_io_oe), 0);
    a_lvl <= 1'b1; wait_clk(6);
    rd(`MFT_ADR_CNT1, 16'hFFFF); rd(`MFT_ADR_RCA, v);
    wr(`MFT_ADR_CNT1, 16'h0055); a_lvl <= 1'b0; wait_clk(6); rd(`MFT_ADR_CNT1, 16'h0055);
    wr(`MFT_ADR_CNT2, v); wr(`MFT_ADR_MODE, 8'hAB); b_lvl <= 1'b1; wait_clk(6);
    rd(`MFT_ADR_CNT2, 16'hFFFF); rd(`MFT_ADR_RCB, v);
    wr(`MFT_ADR_RCA, 3); wr(`MFT_ADR_RCB, 3); wr(`MFT_ADR_CNT1, 3); wr(`MFT_ADR_PRESCALE, 0);
    wr(`MFT_ADR_MODE, 8'hD0); wr(`MFT_ADR_IRQCLR, 8'h0F);
    chk(32'(pin_a_io_oe), 1); chk(32'(pin_a_io_out), 1);
    wr(`MFT_ADR_CLKSEL, 8'h01); prev = pin_a_io_out;
    repeat (200) begin
      @(posedge core_clk);
      if (pin_a_io_out !== prev) toggles++;
      prev = pin_a_io_out;
    end
    wr(`MFT_ADR_CLKSEL, 8'h00); chk(32'(toggles >= 48 && toggles <= 52), 1);
    rd(`MFT_ADR_IRQCTL, 8'h73); chk(32'(timer_irq_one), 1);
    wr(`MFT_ADR_MODE, 8'h90); chk(32'(pin_a_io_out), 0);
    wr(`MFT_ADR_MODE, 8'h50); wait_clk(2); chk(32'(pin_a_io_oe), 0);
    bus(1'b0, `MFT_ADR_CNT1, 0, 1'b0, 0);
    rst <= 1'b1; wait_clk(2); rst <= 1'b0;
    rd(`MFT_ADR_CNT1, got); rd(`MFT_ADR_RCA, 3); rd(`MFT_ADR_RCB, 3);
    rd(`MFT_ADR_CLKSEL, 0); rd(`MFT_ADR_MODE, 0); rd(`MFT_ADR_IRQCTL, 0);
    test_done();
  end
endmodule : testbench
bind mft_timer mft_timer_checker chk (.core_clk, .rst, .wb_req, .wb_ack_o, .wb_dat_o, .pin_a_io_oe,
  .timer_irq_one, .timer_irq_two);
